//--- core/sss_top.sv
`timescale 1ns/100ps
`include "sss_regs.svh"
module sss_top #(
  parameter int TICK_DIV = `SSS_TICK_DIV,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic scl_in, // bus clock pin
  input wire logic sda_in, // bus data pin
  output logic sda_out, // data drive value, always 0
  output logic sda_oe_n, // low while pulling data low
  input wire logic wdog_period_sel_hi, // watchdog select bit 1
  input wire logic wdog_period_sel_lo, // watchdog select bit 0
  input wire logic low_supply_supervisor, // comparator: supply below threshold
  input wire logic backup_switch_policy, // high while on battery backup
  input wire logic nv_busy, // write cycle running
  output logic reset_n, // supervisory reset out, active low
  output logic wr_valid, // write byte available
  input wire logic wr_ready, // write byte taken
  output logic [7:0] wr_data, // write byte
  output logic [15:0] wr_addr, // write byte address
  output logic wr_ctl, // write target is control space
  output logic wr_commit, // stop closed a write, one cycle
  output logic rd_req, // read data needed, one cycle
  output logic [15:0] rd_addr, // read address
  output logic rd_ctl, // read target is control space
  input wire logic [7:0] rd_data, // read byte, valid next cycle
  output logic busy // a transfer is in progress
);
  import sss_pkg::*;
  localparam int TW = 16;
  localparam logic [TW-1:0] T250 = TW'(`SSS_WD_250_MS * `SSS_TICK_HZ / 1000);
  localparam logic [TW-1:0] T750 = TW'(`SSS_WD_750_MS * `SSS_TICK_HZ / 1000);
  localparam logic [TW-1:0] T1750 = TW'(`SSS_WD_1750_MS * `SSS_TICK_HZ / 1000);
  localparam logic [TW-1:0] TRST = TW'(`SSS_RST_TMO_MS * `SSS_TICK_HZ / 1000);

  logic [3:0] sync_q;
  logic scl_s, sda_s, lvr_s, bat_s;
  logic scl_p_q, sda_p_q;
  sss_sync #(.WIDTH(4)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .d({scl_in, sda_in, ~low_supply_supervisor, ~backup_switch_policy}),
    .q(sync_q)
  );
  assign scl_s = sync_q[3];
  assign sda_s = sync_q[2];
  assign lvr_s = ~sync_q[1];
  assign bat_s = ~sync_q[0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  logic start_ev, stop_ev, scl_rise, scl_fall;
  assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;

  // divided timebase for supervisory timers
  logic [31:0] div_q;
  logic tick_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= (div_q == 32'(TICK_DIV - 1));
      div_q <= (div_q == 32'(TICK_DIV - 1)) ? '0 : div_q + 32'h0000_0001;
    end
  end

  // reset timeout: held by power-up, low supply or watchdog bite
  logic [TW-1:0] rst_cnt_q, wd_cnt_q, wd_full;
  logic rst_act_q, wd_bite;
  logic [1:0] wd_sel;
  assign wd_sel = {wdog_period_sel_hi, wdog_period_sel_lo};
  always_comb begin
    case (wd_sel)
      `SSS_WD_P250: wd_full = T250;
      `SSS_WD_P750: wd_full = T750;
      default: wd_full = T1750;
    endcase
  end
  assign wd_bite = !rst_act_q && wd_sel != `SSS_WD_OFF && tick_q && wd_cnt_q == 16'h0001;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_act_q <= 1'b1;
      rst_cnt_q <= TRST;
    end else if (ce) begin
      if (lvr_s) begin
        rst_act_q <= 1'b1;
        rst_cnt_q <= TRST;
      end else if (wd_bite) begin
        rst_act_q <= 1'b1;
        rst_cnt_q <= TRST;
      end else if (rst_act_q && tick_q) begin
        if (rst_cnt_q <= 16'h0001) rst_act_q <= 1'b0;
        else rst_cnt_q <= rst_cnt_q - 16'h0001;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) reset_n <= 1'b0;
    else if (ce) reset_n <= !rst_act_q;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_q <= T1750;
    end else if (ce) begin
      if (wd_sel == `SSS_WD_OFF || rst_act_q) begin
        wd_cnt_q <= wd_full; // starts ignored while reset runs
      end else if (start_ev) begin
        wd_cnt_q <= wd_full;
      end else if (tick_q && wd_cnt_q > 16'h0001) begin
        wd_cnt_q <= wd_cnt_q - 16'h0001;
      end else if (wd_bite) begin
        wd_cnt_q <= wd_full;
      end
    end
  end

  // serial engine; low supply aborts it, a running write is not touched
  logic lvr_abort;
  assign lvr_abort = lvr_s; // nv_busy left to finish
  sss_state_t st_q;
  sss_target_t tgt_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [15:0] addr_q;
  logic ack_slot_q, rd_mode_q, wrote_q, any_wr_q, ack_drv_q, tx_drv_q;
  logic fifo_in_valid, fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic [7:0] tx_q;
  logic rd_pend_q;

  wire byte_done = scl_fall && bit_q == 4'd8 && !ack_slot_q;
  wire [7:0] rx_byte = sh_q;
  wire sel_mem = rx_byte[7:4] == `SSS_SEL_MEM_V;
  wire sel_ctl = rx_byte[7:4] == `SSS_SEL_CTL_V;
  wire sel_ok = (sel_mem || sel_ctl) && rx_byte[3:1] == `SSS_DEV_SEL;
  // busy write cycle refuses the slave byte so ack polling works
  wire can_ack = sel_ok && !nv_busy && !lvr_abort && (rx_byte[0] || fifo_in_ready);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= SSS_IDLE;
      tgt_q <= SSS_TGT_NONE;
      bit_q <= '0;
      sh_q <= '0;
      ack_slot_q <= 1'b0;
      ack_drv_q <= 1'b0;
      rd_mode_q <= 1'b0;
      wrote_q <= 1'b0;
      any_wr_q <= 1'b0;
      addr_q <= `SSS_ADDR_RST;
      rd_pend_q <= 1'b0;
    end else if (ce) begin
      rd_pend_q <= 1'b0;
      if (lvr_abort || stop_ev) begin
        st_q <= SSS_IDLE;
        ack_drv_q <= 1'b0;
        ack_slot_q <= 1'b0;
        bit_q <= '0;
      end else if (start_ev) begin
        st_q <= SSS_SLAVE;
        bit_q <= '0;
        ack_slot_q <= 1'b0;
        ack_drv_q <= 1'b0;
        wrote_q <= 1'b0;
      end else if (st_q != SSS_IDLE && st_q != SSS_IGNORE) begin
        if (scl_rise && !ack_slot_q && bit_q < 4'd8) begin
          sh_q <= {sh_q[6:0], sda_s};
          bit_q <= bit_q + 4'd1;
        end else if (byte_done) begin
          ack_slot_q <= 1'b1;
          bit_q <= '0;
          case (st_q)
            SSS_SLAVE: begin
              ack_drv_q <= can_ack;
              if (!can_ack) st_q <= SSS_IGNORE;
              tgt_q <= sel_ctl ? SSS_TGT_CTL : SSS_TGT_MEM;
              rd_mode_q <= rx_byte[0];
              // fetch during the ack slot so bit 7 is out before the next rise
              rd_pend_q <= can_ack && rx_byte[0];
            end
            SSS_ADRH: begin
              ack_drv_q <= 1'b1;
              addr_q[15:8] <= rx_byte;
            end
            SSS_ADRL: begin
              ack_drv_q <= 1'b1;
              addr_q[7:0] <= rx_byte;
            end
            SSS_WDATA: begin
              ack_drv_q <= fifo_in_ready;
              if (fifo_in_ready) begin
                wrote_q <= 1'b1;
                addr_q <= addr_q + 16'h0001;
              end
            end
            SSS_RDATA: begin
              ack_drv_q <= 1'b0; // master answers
              addr_q <= addr_q + 16'h0001;
              rd_pend_q <= 1'b1;
            end
            default: ack_drv_q <= 1'b0;
          endcase
        end else if (scl_rise && ack_slot_q && st_q == SSS_RDATA) begin
          if (sda_s) st_q <= SSS_IGNORE;
        end else if (scl_fall && ack_slot_q) begin
          ack_slot_q <= 1'b0;
          ack_drv_q <= 1'b0;
          case (st_q)
            SSS_SLAVE: begin
              st_q <= rd_mode_q ? SSS_RDATA : SSS_ADRH;
            end
            SSS_ADRH: st_q <= SSS_ADRL;
            SSS_ADRL: st_q <= SSS_WDATA;
            default: st_q <= st_q;
          endcase
        end
      end
      if (stop_ev) any_wr_q <= wrote_q;
      else any_wr_q <= 1'b0;
    end
  end

  // read byte: request, then load shift register one cycle later
  logic rd_load_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_load_q <= 1'b0;
      tx_q <= '0;
      tx_drv_q <= 1'b0;
      rd_req <= 1'b0;
      rd_addr <= '0;
      rd_ctl <= 1'b0;
    end else if (ce) begin
      rd_req <= rd_pend_q;
      rd_addr <= addr_q;
      rd_ctl <= tgt_q == SSS_TGT_CTL;
      rd_load_q <= rd_req;
      if (rd_load_q) tx_q <= rd_data;
      else if (st_q == SSS_RDATA && scl_fall && !ack_slot_q && bit_q != 4'd8)
        tx_q <= {tx_q[6:0], 1'b1};
      // release when the ack slot opens; a stop or low supply releases at once, whatever the clock
      tx_drv_q <= st_q == SSS_RDATA && !ack_slot_q && !tx_q[7]
                  && !(lvr_abort || stop_ev);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
      busy <= 1'b0;
      wr_commit <= 1'b0;
    end else if (ce) begin
      sda_oe_n <= !(ack_drv_q || tx_drv_q);
      sda_out <= 1'b0;
      busy <= st_q != SSS_IDLE;
      wr_commit <= any_wr_q && !lvr_abort;
    end
  end

  assign fifo_in_valid = ce && byte_done && st_q == SSS_WDATA && !lvr_abort && !stop_ev;
  assign fifo_in_data = rx_byte;
  logic [24:0] fifo_out;
  logic fifo_out_valid;
  // bytes carry their address so the drain may lag the bus
  sss_fifo #(.WIDTH(25), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({tgt_q == SSS_TGT_CTL, addr_q, fifo_in_data}),
    .out_valid(fifo_out_valid),
    .out_ready(wr_ready && wr_valid),
    .out_data(fifo_out),
    .flush(1'b0)
  );
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr_data <= '0;
      wr_addr <= '0;
      wr_ctl <= 1'b0;
    end else if (ce) begin
      wr_valid <= fifo_out_valid && !(wr_ready && wr_valid);
      wr_data <= fifo_out[7:0];
      wr_addr <= fifo_out[23:8];
      wr_ctl <= fifo_out[24];
    end
  end
endmodule : sss_top

//--- core/sss_regs.svh
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH
`define SSS_CLK_HZ 50000000
`define SSS_TICK_HZ 1000
`define SSS_TICK_DIV (`SSS_CLK_HZ / `SSS_TICK_HZ)
`define SSS_WD_250_MS 250
`define SSS_WD_750_MS 750
`define SSS_WD_1750_MS 1750
`define SSS_RST_TMO_MS 250
`define SSS_SEL_MEM 4'ha
`define SSS_SEL_MEM_V 4'b1010
`define SSS_SEL_CTL_V 4'b1101
`define SSS_DEV_SEL 3'b111
`define SSS_WD_OFF 2'b11
`define SSS_WD_P250 2'b10
`define SSS_WD_P750 2'b01
`define SSS_WD_P1750 2'b00
`define SSS_ADDR_RST 16'h0000
`endif

//--- core/sss_pkg.sv
package sss_pkg;
  typedef enum logic [2:0] {
    SSS_IDLE, SSS_SLAVE, SSS_ADRH, SSS_ADRL, SSS_WDATA, SSS_RDATA, SSS_RACK, SSS_IGNORE
  } sss_state_t;
  typedef enum logic [1:0] {SSS_TGT_MEM, SSS_TGT_CTL, SSS_TGT_NONE} sss_target_t;
endpackage : sss_pkg

//--- core/sss_fifo.sv
`timescale 1ns/100ps
module sss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk, // clock
  input wire logic nrst, // async reset
  input wire logic ce, // clock enable
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // not empty
  input wire logic out_ready, // drain
  output logic [WIDTH-1:0] out_data, // head word
  input wire logic flush // drop contents
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic do_wr, do_rd;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        if (do_wr) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
        if (do_rd) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
        cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (ce && do_wr && !flush) mem_q[wr_q] <= in_data;
  end
endmodule : sss_fifo

//--- core/sss_sync.sv
`timescale 1ns/100ps
module sss_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk, // clock
  input wire logic nrst, // async reset
  input wire logic ce, // clock enable
  input wire logic [WIDTH-1:0] d, // async inputs
  output logic [WIDTH-1:0] q // synchronised
);
  logic [WIDTH-1:0] s1_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          s1_q[i] <= 1'b1;
          q[i] <= 1'b1;
        end else if (ce) begin
          s1_q[i] <= d[i];
          q[i] <= s1_q[i];
        end
      end
    end
  endgenerate
endmodule : sss_sync

//--- verification/sss_chk.sv
`timescale 1ns/100ps
module sss_chk #(
  parameter int TICK_DIV = 10
) (
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset
  input wire logic scl_in, // bus clock
  input wire logic sda_in, // bus data
  input wire logic sda_out, // drive value
  input wire logic sda_oe_n, // drive enable
  input wire logic low_supply_supervisor, // supply low
  input wire logic reset_n, // reset out
  input wire logic wr_valid, // write valid
  input wire logic wr_ready, // write ready
  input wire logic [7:0] wr_data, // write byte
  input wire logic wr_commit, // commit pulse
  input wire logic rd_req, // read pulse
  input wire logic busy // transfer busy
);
  localparam int MIN_LO = 249 * TICK_DIV;
  localparam int MAX_LO = 251 * TICK_DIV + 8;
  int ok_q;
  // held-reset cycles with supply good; a low supply restarts the wait
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) ok_q <= 0;
    else if (reset_n || low_supply_supervisor) ok_q <= 0;
    else ok_q <= ok_q + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_rst_min_hold: assert property ($rose(reset_n) |-> ok_q >= MIN_LO)
    else $error("reset released early");
  a_rst_max_hold: assert property (ok_q <= MAX_LO)
    else $error("reset held too long");
  a_low_supply_rst: assert property (low_supply_supervisor [*5] |-> !reset_n)
    else $error("reset not low under low supply");
  a_low_supply_quiet: assert property (low_supply_supervisor [*8] |-> sda_oe_n)
    else $error("data driven under low supply");
  a_ack_scl_low: assert property ($changed(sda_oe_n) |-> !$past(scl_in))
    else $error("data changed while clock high");
  a_drive_zero: assert property (!sda_oe_n |-> !sda_out)
    else $error("data driven high");
  a_stop_idle: assert property (scl_in && $rose(sda_in) |-> ##[2:8] !busy)
    else $error("stop did not end transfer");
  a_rd_pulse: assert property (rd_req |=> !rd_req)
    else $error("read request longer than one cycle");
  a_commit_pulse: assert property (wr_commit |=> !wr_commit)
    else $error("commit longer than one cycle");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write byte dropped while stalled");
  c_commit: cover property (wr_commit);
  c_read: cover property (rd_req);
  c_wd_reset: cover property ($fell(reset_n) && !low_supply_supervisor);
  c_stall: cover property (wr_valid && !wr_ready);
endmodule : sss_chk
bind sss_top sss_chk #(.TICK_DIV(TICK_DIV)) u_chk (.ref_clk, .nrst, .scl_in, .sda_in,
  .sda_out, .sda_oe_n, .low_supply_supervisor, .reset_n, .wr_valid, .wr_ready, .wr_data,
  .wr_commit, .rd_req, .busy);

//--- verification/sss_master.sv
`timescale 1ns/100ps
module sss_master (
  output logic scl, // bus clock, high when idle
  output logic sda_lo, // high pulls data low
  input wire logic sda // resolved data line
);
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  task automatic start();
    #60 sda_lo = 1'b0;
    #60 scl = 1'b1;
    #80 sda_lo = 1'b1;
    #80 scl = 1'b0;
  endtask : start
  task automatic stop();
    #60 sda_lo = 1'b1;
    #60 scl = 1'b1;
    #80 sda_lo = 1'b0;
  endtask : stop
  // data only moves while clock is low; long low phase covers the slave's sync delay
  task automatic bit_io(input logic b, output logic s);
    #60 sda_lo = !b;
    #60 scl = 1'b1;
    #20 s = sda;
    #20 scl = 1'b0;
  endtask : bit_io
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(!ack, s);
  endtask : rbyte
endmodule : sss_master

//--- verification/test_serial_slave_supervisor.sv
`timescale 1ns/100ps
module test_serial_slave_supervisor;
  localparam int TD = 10;
  logic ref_clk = 1'b0, nrst = 1'b0, nv_busy = 1'b0, low_sup = 1'b0;
  logic wr_ready = 1'b1, stall = 1'b0, scl, sda_lo, sda;
  logic sda_out, sda_oe_n, reset_n, wr_valid, wr_ctl, wr_commit, rd_req, rd_ctl, busy;
  logic [1:0] wd_sel = 2'b11;
  logic [7:0] wr_data, rd_data;
  logic [15:0] wr_addr, rd_addr;
  logic [31:0] lfsr = 32'hefbe_2af7, rs = 32'hefbe_2af7;
  logic [24:0] wq[$];
  int num_errors = 0, n_checks = 0, commits = 0;
  always #10 ref_clk = !ref_clk;
  assign sda = !sda_lo && (sda_oe_n || sda_out); // pull-up when released
  assign rd_data = exp_rd(rd_addr, rd_ctl);
  sss_top #(.TICK_DIV(TD), .FIFO_DEPTH(16)) uut (.ref_clk, .nrst, .ce(1'b1), .scl_in(scl),
    .sda_in(sda), .sda_out, .sda_oe_n, .wdog_period_sel_hi(wd_sel[1]),
    .wdog_period_sel_lo(wd_sel[0]), .low_supply_supervisor(low_sup),
    .backup_switch_policy(1'b0), .nv_busy, .reset_n, .wr_valid, .wr_ready, .wr_data,
    .wr_addr, .wr_ctl, .wr_commit, .rd_req, .rd_addr, .rd_ctl, .rd_data, .busy);
  sss_master m (.scl, .sda_lo, .sda);
  function automatic logic [7:0] exp_rd(input logic [15:0] a, input logic c);
    return a[7:0] ^ a[15:8] ^ {c, 7'h25};
  endfunction : exp_rd
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  always @(posedge ref_clk) begin
    if (wr_valid && wr_ready) wq.push_back({wr_ctl, wr_addr, wr_data});
    if (wr_commit) commits++;
    #1 rs = nxt(rs);
    wr_ready = !stall && rs[3];
  end
  task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // master moves land 1 ns after a clock edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wait_rel(output int n);
    n = 0;
    while (reset_n !== 1'b1 && n < 300 * TD) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
  endtask : wait_rel
  task automatic xfer_addr(input logic [7:0] slv, input logic [15:0] a, output int acks);
    logic k;
    m.start();
    m.wbyte(slv, k);
    acks = k;
    m.wbyte(a[15:8], k);
    acks += k;
    m.wbyte(a[7:0], k);
    acks += k;
  endtask : xfer_addr
  task automatic wr_run(input logic [7:0] slv, input int nb, output int na);
    logic [15:0] a;
    logic [7:0] d[$];
    logic k;
    int h, c0;
    lfsr = nxt(lfsr);
    a = lfsr[23:8];
    c0 = commits;
    xfer_addr(slv, a, h);
    chk(h, 3, "write header acks");
    repeat (nb) begin
      lfsr = nxt(lfsr);
      m.wbyte(lfsr[7:0], k);
      if (k) d.push_back(lfsr[7:0]);
    end
    m.stop();
    na = d.size();
    stall = 1'b0;
    cyc(200);
    chk(wq.size(), na, "stream length");
    foreach (d[i]) begin
      if (wq.size() > 0) chk(wq.pop_front(), {slv[6], a + 16'(i), d[i]}, "word");
    end
    if (na == nb) chk(commits, c0 + 1, "commit count");
  endtask : wr_run
  task automatic rd_run(input logic [7:0] slv, input logic setaddr, input logic [15:0] a,
                        input int nb);
    logic k;
    logic [7:0] v;
    int h;
    if (setaddr) xfer_addr(slv & 8'hfe, a, h);
    m.start();
    m.wbyte(slv, k);
    chk(k, 1'b1, "read slave ack");
    for (int i = 0; i < nb; i++) begin
      m.rbyte(i < nb - 1, v);
      chk(v, exp_rd(a + 16'(i), slv[6]), "read byte");
    end
    m.stop();
  endtask : rd_run
  initial begin
    #1_600_000;
    num_errors++;
    $display("[ERR] %0t run timeout", $time);
    report_and_stop();
  end
  initial begin
    logic [7:0] bad[4] = '{8'ha6, 8'hbe, 8'hdc, 8'hae};
    logic [1:0] wc[3] = '{2'b10, 2'b01, 2'b00};
    int wl[3] = '{250, 750, 1750};
    int n;
    logic k;
    cyc(4);
    nrst = 1'b1;
    wait_rel(n);
    chk(n >= 249 * TD && n <= 253 * TD, 1'b1, "power-on release");
    rd_run(8'haf, 1'b0, 16'h0000, 1);
    foreach (bad[i]) begin
      nv_busy = (i == 3);
      m.start();
      m.wbyte(bad[i], k);
      m.stop();
      chk(k, 1'b0, "refused slave byte");
    end
    nv_busy = 1'b0;
    stall = 1'b1;
    wr_run(8'hae, 18, n);
    chk(n >= 16 && n <= 17, 1'b1, "fifo fill");
    wr_run(8'hde, 3, n);
    lfsr = nxt(lfsr);
    rd_run(8'haf, 1'b1, lfsr[15:0], 2);
    rd_run(8'haf, 1'b0, lfsr[15:0] + 16'h0002, 1);
    rd_run(8'hdf, 1'b1, lfsr[31:16], 2);
    low_sup = 1'b1;
    cyc(8);
    chk(reset_n, 1'b0, "low supply reset");
    m.start();
    m.wbyte(8'hae, k);
    m.stop();
    chk(k, 1'b0, "refused under low supply");
    cyc(1);
    low_sup = 1'b0;
    wait_rel(n);
    chk(n >= 249 * TD && n <= 254 * TD, 1'b1, "low supply release");
    foreach (wc[i]) begin
      wd_sel = wc[i];
      m.start();
      m.stop();
      cyc(wl[i] * TD / 2);
      m.start();
      m.stop();
      cyc((wl[i] - 5) * TD);
      chk(reset_n, 1'b1, "watchdog early");
      n = 0;
      while (reset_n === 1'b1 && n < 10 * TD) begin
        @(posedge ref_clk);
        n++;
      end
      #1 chk(reset_n, 1'b0, "watchdog expiry");
      m.start();
      m.stop();
      cyc(1);
      wd_sel = 2'b11;
      wait_rel(n);
      chk(n >= 245 * TD && n <= 252 * TD, 1'b1, "reset timeout");
    end
    report_and_stop();
  end
endmodule : test_serial_slave_supervisor
